//--- hdl/six_pin_io_pkg.sv
package six_pin_io_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int PINS = 6;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [2:0] PORT_PIN_LEVELS_ADDR = 3'h0;
   localparam logic [2:0] PIN_DIRECTION_ADDR = 3'h1;
   localparam logic [2:0] ANALOG_SELECT_ADDR = 3'h2;
   localparam logic [2:0] PULLUP_ENABLE_ADDR = 3'h3;
   localparam logic [2:0] CHANGE_IRQ_ENABLE_ADDR = 3'h4;
   localparam logic [2:0] INTERRUPT_CONTROL_ADDR = 3'h5;
   localparam logic [2:0] OPTION_ADDR = 3'h6;
   localparam logic [2:0] PORT_BIT_MODIFY_ADDR = 3'h7;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int INPUT_ONLY_BIT = 3;
   localparam int CHANGE_FLAG_BIT = 0;
   localparam int GLOBAL_PULLUP_BIT = 7;
   localparam int BIT_MODIFY_VALUE_BIT = 3;
   localparam logic [5:0] OSC_PIN_MASK = 6'h30;
   localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [5:0] DIRECTION_RST = 6'h3F;
   localparam logic [5:0] ANALOG_SELECT_RST = 6'h17;
   localparam logic [5:0] PULLUP_ENABLE_RST = 6'h37;
   localparam logic [5:0] CHANGE_IRQ_ENABLE_RST = 6'h00;
   localparam logic [5:0] OUTPUT_LATCH_RST = 6'h00;
   localparam logic GLOBAL_PULLUP_RST = 1'b1;

   // ------------------------------------------------------------
   // oscillator mode codes
   // ------------------------------------------------------------
   localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'h0;
   localparam logic [2:0] MEDIUM_GAIN_CRYSTAL_MODE = 3'h1;
   localparam logic [2:0] HIGH_GAIN_CRYSTAL_MODE = 3'h2;

endpackage

//--- hdl/six_pin_io_port.sv
`timescale 1ns/100ps
module six_pin_io_port
   import six_pin_io_pkg::*;
#(
   parameter int NUM_PINS = PINS
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic warm_reset,
   input wire logic master_clear_pin_enable,
   input wire logic [2:0] osc_mode,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe_n,
   output logic [NUM_PINS-1:0] pullup_on,
   output logic [NUM_PINS-1:0] digital_input_enable,
   output logic change_irq_flag,
   output logic wake_request
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   // crystal modes steal the two oscillator pins, so their bits read as one
   function automatic logic [5:0] osc_force(input logic [5:0] val, input logic xtal);
      osc_force = xtal ? (val | OSC_PIN_MASK) : val;
   endfunction

   function automatic logic [DATA_W-1:0] pad_byte(input logic [5:0] val);
      pad_byte = {2'h0, val};
   endfunction

   function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target);
      reg_hit = strobe && (addr == target);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] latch_q;
   logic [5:0] latch_d;
   logic [5:0] dir_q;
   logic [5:0] dir_d;
   logic [5:0] analog_q;
   logic [5:0] analog_d;
   logic [5:0] wpu_q;
   logic [5:0] wpu_d;
   logic [5:0] ioc_q;
   logic [5:0] ioc_d;
   logic global_pullup_off_q;
   logic global_pullup_off_d;
   logic [5:0] last_read_q;
   logic [5:0] last_read_d;
   logic flag_q;
   logic flag_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   wire crystal_mode = (osc_mode == LOW_POWER_CRYSTAL_MODE) ||
                       (osc_mode == MEDIUM_GAIN_CRYSTAL_MODE) ||
                       (osc_mode == HIGH_GAIN_CRYSTAL_MODE);
   wire wr_port = reg_hit(reg_write, reg_addr, PORT_PIN_LEVELS_ADDR);
   wire wr_dir = reg_hit(reg_write, reg_addr, PIN_DIRECTION_ADDR);
   wire wr_analog = reg_hit(reg_write, reg_addr, ANALOG_SELECT_ADDR);
   wire wr_wpu = reg_hit(reg_write, reg_addr, PULLUP_ENABLE_ADDR);
   wire wr_ioc = reg_hit(reg_write, reg_addr, CHANGE_IRQ_ENABLE_ADDR);
   wire wr_intctl = reg_hit(reg_write, reg_addr, INTERRUPT_CONTROL_ADDR);
   wire wr_option = reg_hit(reg_write, reg_addr, OPTION_ADDR);
   wire wr_bitmod = reg_hit(reg_write, reg_addr, PORT_BIT_MODIFY_ADDR);
   wire rd_port = reg_hit(reg_read, reg_addr, PORT_PIN_LEVELS_ADDR);
   wire port_touch = rd_port || wr_port || wr_bitmod;

   // ------------------------------------------------------------
   // pin read path
   // ------------------------------------------------------------
   // analog pins and a master-clear input-only pin read as zero
   wire [5:0] read_mask = analog_q | (master_clear_pin_enable ? INPUT_ONLY_MASK : 6'h00);
   wire [5:0] pin_levels = sync2_q & ~read_mask;

   // ------------------------------------------------------------
   // direction and drivers
   // ------------------------------------------------------------
   // driver follows direction even for analog pins; keeping it off is software's job
   wire [5:0] dir_eff = osc_force(dir_q | INPUT_ONLY_MASK, crystal_mode);
   wire [5:0] dir_view = dir_eff;

   // ------------------------------------------------------------
   // pull-ups
   // ------------------------------------------------------------
   wire [5:0] wpu_view = osc_force(wpu_q & ~INPUT_ONLY_MASK, crystal_mode);
   wire [5:0] wpu_gated = wpu_q & dir_eff & ~analog_q & ~INPUT_ONLY_MASK &
                          {6{~global_pullup_off_q}};
   wire [5:0] wpu_master_clear_input = master_clear_pin_enable ? INPUT_ONLY_MASK : 6'h00;

   // ------------------------------------------------------------
   // change detection
   // ------------------------------------------------------------
   wire [5:0] mismatch = ioc_q & ~analog_q & (pin_levels ^ last_read_q);
   wire any_mismatch = |mismatch;

   // ------------------------------------------------------------
   // bit modify operand
   // ------------------------------------------------------------
   wire [2:0] bm_index = reg_wdata[2:0];
   wire bm_value = reg_wdata[BIT_MODIFY_VALUE_BIT];
   logic [5:0] bm_result;

   always_comb begin
      bm_result = pin_levels;
      if (bm_index < 3'h6) begin
         bm_result[bm_index] = bm_value;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      latch_d = latch_q;
      if (wr_port) begin
         latch_d = reg_wdata[5:0];
      end else if (wr_bitmod) begin
         // pin levels, not the latch, feed the merge: an analog output pin reads zero
         latch_d = bm_result;
      end
   end

   assign dir_d = wr_dir ? reg_wdata[5:0] : dir_q;
   assign analog_d = wr_analog ? reg_wdata[5:0] : analog_q;
   assign wpu_d = wr_wpu ? reg_wdata[5:0] : wpu_q;
   assign ioc_d = wr_ioc ? reg_wdata[5:0] : ioc_q;
   assign global_pullup_off_d = wr_option ? reg_wdata[GLOBAL_PULLUP_BIT] : global_pullup_off_q;

   // any port access refreshes the compare latch, but a change in that same cycle
   // is still compared against the old latch value and flagged
   assign last_read_d = port_touch ? pin_levels : last_read_q;

   // set beats clear: a live mismatch keeps the flag up
   always_comb begin
      flag_d = flag_q;
      if (wr_intctl && !reg_wdata[CHANGE_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (any_mismatch) begin
         flag_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      rdata_d = '0;
      if (reg_read) begin
         unique case (reg_addr)
            PORT_PIN_LEVELS_ADDR: rdata_d = pad_byte(pin_levels);
            PIN_DIRECTION_ADDR: rdata_d = pad_byte(dir_view);
            ANALOG_SELECT_ADDR: rdata_d = pad_byte(analog_q);
            PULLUP_ENABLE_ADDR: rdata_d = pad_byte(wpu_view);
            CHANGE_IRQ_ENABLE_ADDR: rdata_d = pad_byte(ioc_q);
            INTERRUPT_CONTROL_ADDR: rdata_d = {7'h00, flag_q};
            OPTION_ADDR: rdata_d = {global_pullup_off_q, 7'h00};
            PORT_BIT_MODIFY_ADDR: rdata_d = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // synchronizer
   // ------------------------------------------------------------
   // only the second stage is read; the first may still be settling
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= pin_in[5:0];
         sync2_q <= sync1_q;
      end
   end

   // ------------------------------------------------------------
   // compare latch: power-on reset only
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         last_read_q <= 6'h00;
      end else begin
         last_read_q <= last_read_d;
      end
   end

   // ------------------------------------------------------------
   // output latch
   // ------------------------------------------------------------
   // warm resets leave the latch alone, but direction resets to input so a driven pin stops driving
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         latch_q <= OUTPUT_LATCH_RST;
      end else if (!warm_reset) begin
         latch_q <= latch_d;
      end
   end

   // ------------------------------------------------------------
   // direction
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dir_q <= DIRECTION_RST;
      end else if (warm_reset) begin
         dir_q <= DIRECTION_RST;
      end else begin
         dir_q <= dir_d;
      end
   end

   // ------------------------------------------------------------
   // analog select
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         analog_q <= ANALOG_SELECT_RST;
      end else if (warm_reset) begin
         analog_q <= ANALOG_SELECT_RST;
      end else begin
         analog_q <= analog_d;
      end
   end

   // ------------------------------------------------------------
   // pull-up enables
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wpu_q <= PULLUP_ENABLE_RST;
      end else if (warm_reset) begin
         wpu_q <= PULLUP_ENABLE_RST;
      end else begin
         wpu_q <= wpu_d;
      end
   end

   // ------------------------------------------------------------
   // change enables
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ioc_q <= CHANGE_IRQ_ENABLE_RST;
      end else if (warm_reset) begin
         ioc_q <= CHANGE_IRQ_ENABLE_RST;
      end else begin
         ioc_q <= ioc_d;
      end
   end

   // ------------------------------------------------------------
   // option: global pull-up control
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         global_pullup_off_q <= GLOBAL_PULLUP_RST;
      end else if (warm_reset) begin
         global_pullup_off_q <= GLOBAL_PULLUP_RST;
      end else begin
         global_pullup_off_q <= global_pullup_off_d;
      end
   end

   // ------------------------------------------------------------
   // flag and read data
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_q <= 1'h0;
      end else if (warm_reset) begin
         flag_q <= any_mismatch;
      end else begin
         flag_q <= flag_d;
      end
   end

   // read data stand for one cycle only; idle cycles return zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else if (warm_reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   generate
      for (genvar i = 0; i < 6; i++) begin : g_pin
         assign pin_out[i] = (i == INPUT_ONLY_BIT) ? 1'b0 : latch_q[i];
         assign pin_oe_n[i] = (i == INPUT_ONLY_BIT) ? 1'b1 : dir_eff[i];
         assign pullup_on[i] = wpu_gated[i] | wpu_master_clear_input[i];
         assign digital_input_enable[i] = ~analog_q[i];
      end
   endgenerate

   assign reg_rdata = rdata_q;
   assign change_irq_flag = flag_q;
   assign wake_request = flag_q;

endmodule

//--- test/six_pin_io_port_assertions.sv
`timescale 1ns/100ps
module six_pin_io_port_assertions
   import six_pin_io_pkg::*;
#(
   parameter int NUM_PINS = PINS
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic master_clear_pin_enable,
   input wire logic [2:0] osc_mode,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe_n,
   input wire logic [NUM_PINS-1:0] pullup_on,
   input wire logic [NUM_PINS-1:0] digital_input_enable,
   input wire logic change_irq_flag,
   input wire logic wake_request
);
   // ------------------------------------------------------------
   // port relations
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_INPUT_ONLY_UNDRIVEN: assert property (pin_oe_n[3] && !pin_out[3])
      else $error("input-only pin driven");
   AST_DIR_READBACK: assert property (reg_read && reg_addr == PIN_DIRECTION_ADDR
      |=> reg_rdata[3] && reg_rdata[7:6] == 2'h0) else $error("direction readback wrong");
   AST_CRYSTAL_DIR: assert property (reg_read && reg_addr == PIN_DIRECTION_ADDR
      && osc_mode < 3'h3 |=> reg_rdata[5:4] == 2'h3) else $error("oscillator bits not one");
   AST_PORT_MASK: assert property (reg_read && reg_addr == PORT_PIN_LEVELS_ADDR
      |=> (reg_rdata & ~{2'h0, $past(digital_input_enable)}) == 8'h00)
      else $error("masked port bits not zero");
   AST_MASTER_CLEAR_INPUT_READ: assert property (reg_read && reg_addr == PORT_PIN_LEVELS_ADDR
      && master_clear_pin_enable |=> !reg_rdata[3]) else $error("master clear bit read one");
   // a pull-up fighting an active driver would only waste current
   AST_PULLUP_GATE: assert property ((pullup_on & ~pin_oe_n) == 6'h00
      && (pullup_on & ~digital_input_enable & ~INPUT_ONLY_MASK) == 6'h00)
      else $error("pull-up on for output or analog pin");
   AST_MASTER_CLEAR_INPUT_PULLUP: assert property (pullup_on[3] == master_clear_pin_enable)
      else $error("input-only pull-up wrong");
   AST_WAKE: assert property (wake_request == change_irq_flag)
      else $error("wake request does not follow flag");
endmodule
bind six_pin_io_port six_pin_io_port_assertions #(.NUM_PINS(NUM_PINS)) chk_i (
   .sys_clk, .rstn, .master_clear_pin_enable, .osc_mode, .reg_addr, .reg_read, .reg_rdata,
   .pin_out, .pin_oe_n, .pullup_on, .digital_input_enable, .change_irq_flag, .wake_request);

//--- test/pin_board_model.sv
`timescale 1ns/100ps
module pin_board_model (
   input wire logic sys_clk,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic [5:0] pullup_on,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_in
);
   logic [5:0] last_q = 6'h00;
   // a floating pin toggles so that no settled value can pass for a real level
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pullup_on[i]) pin_in[i] = 1'b1;
         else pin_in[i] = ~last_q[i];
      end
   end
   always @(posedge sys_clk) last_q <= pin_in;
endmodule

//--- test/six_pin_io_port_tb.sv
`timescale 1ns/100ps
module six_pin_io_port_tb;
   import six_pin_io_pkg::*;
   logic sys_clk = 0, rstn = 0, warm_reset = 0, master_clear_pin_enable = 0;
   logic [2:0] osc_mode = 3'h4, reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic reg_write = 0, reg_read = 0, change_irq_flag, wake_request;
   logic [5:0] pin_in, pin_out, pin_oe_n, pullup_on, digital_input_enable;
   logic [5:0] ext_en = 6'h3F, ext_val = 6'h00;
   int bad_count = 0, checked = 0;
   always #20 sys_clk = ~sys_clk;
   six_pin_io_port DUT (.sys_clk, .rstn, .warm_reset, .master_clear_pin_enable, .osc_mode,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pin_in, .pin_out, .pin_oe_n,
      .pullup_on, .digital_input_enable, .change_irq_flag, .wake_request);
   pin_board_model board (.sys_clk, .pin_out, .pin_oe_n, .pullup_on, .ext_en, .ext_val,
      .pin_in);
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 0;
      #1;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 0;
      #1 chk(reg_rdata, exp);
   endtask
   // pins pass two synchroniser stages before use
   task settle;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task results;
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      results();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1;
      rd(1, 8'h3F);
      rd(2, 8'h17);
      rd(3, 8'h37);
      rd(4, 8'h00);
      rd(7, 8'h00);
      chk(pullup_on, 8'h00);
      wr(2, 8'h00);
      wr(6, 8'h00);
      chk(pullup_on, 8'h37);
      wr(3, 8'h05);
      chk(pullup_on, 8'h05);
      wr(0, 8'h3A);
      wr(1, 8'hC0);
      chk(pin_oe_n, 8'h08);
      chk(pin_out, 8'h32);
      chk(pullup_on, 8'h00);
      rd(1, 8'h08);
      settle();
      rd(0, 8'h32);
      @(posedge sys_clk) ext_val <= 6'h08;
      settle();
      rd(0, 8'h3A);
      @(posedge sys_clk) master_clear_pin_enable <= 1;
      settle();
      rd(0, 8'h32);
      chk(pullup_on, 8'h08);
      @(posedge sys_clk) master_clear_pin_enable <= 0;
      wr(2, 8'h03);
      settle();
      rd(0, 8'h38);
      chk(pin_out, 8'h32);
      chk(digital_input_enable, 8'h3C);
      wr(1, 8'h3C);
      chk(pin_oe_n, 8'h3C);
      wr(1, 8'h3F);
      wr(2, 8'h04);
      chk(pullup_on, 8'h01);
      wr(2, 8'h00);
      @(posedge sys_clk) ext_val <= 6'h15;
      settle();
      wr(7, 8'h09);
      chk(pin_out, 8'h17);
      wr(7, 8'h0E);
      chk(pin_out, 8'h15);
      wr(1, 8'h00);
      for (int m = 0; m < 3; m++) begin
         @(posedge sys_clk) osc_mode <= m[2:0];
         rd(1, 8'h38);
         rd(3, 8'h35);
      end
      @(posedge sys_clk) osc_mode <= 3'h4;
      wr(1, 8'h3F);
      wr(4, 8'h06);
      settle();
      rd(0, 8'h15);
      chk(change_irq_flag, 8'h00);
      @(posedge sys_clk) ext_val <= 6'h11;
      settle();
      chk(change_irq_flag, 8'h01);
      chk(wake_request, 8'h01);
      wr(5, 8'h00);
      chk(change_irq_flag, 8'h01);
      rd(0, 8'h11);
      wr(5, 8'h00);
      chk(change_irq_flag, 8'h00);
      wr(2, 8'h02);
      @(posedge sys_clk) ext_val <= 6'h13;
      settle();
      chk(change_irq_flag, 8'h00);
      wr(2, 8'h00);
      settle();
      chk(change_irq_flag, 8'h01);
      @(posedge sys_clk) warm_reset <= 1;
      @(posedge sys_clk) warm_reset <= 0;
      #1 chk(change_irq_flag, 8'h01);
      chk(pin_out, 8'h15);
      wr(2, 8'h00);
      wr(4, 8'h01);
      wr(5, 8'h00);
      chk(change_irq_flag, 8'h00);
      wr(4, 8'h02);
      settle();
      chk(change_irq_flag, 8'h01);
      results();
   end
endmodule
